// file: rtl/mprc_pkg.sv
// constants, types and register map of the module power and reset control
// ****************************************************************
// Operation
// [R1] host reset low 0.5-3 s resets module
// [R2] enable high over 1.2 s powers on
// [R3] enable low while on powers off
// [R4] host waits 40 ms after supply
// [R5] host enable GPIO resets low
// [R6] host spaces resets by 20 s
// [R7] lamp low while radio enabled; the code lights it only while also in PWR_ON
// [R8] card sense high means inserted
// [R9] hot-plug detection enabled by default
// [R10] hot-plug disable applies after restart
// [R11] card sense debounced before events
// ****************************************************************
package mprc_pkg;

  // ****************************************************************
  // timing
  // ****************************************************************
  localparam int unsigned CLK_KHZ     = 250_000;
  localparam int unsigned PWR_ON_MS   = 1200;
  localparam int unsigned RST_MIN_MS  = 500;
  localparam int unsigned RST_MAX_MS  = 3000;
  localparam int unsigned DEB_TICK_MS = 1;
  // products are exact, so rounding up and down agree
  localparam logic [31:0] PWR_ON_CYC   = 32'(CLK_KHZ * PWR_ON_MS);
  localparam logic [31:0] RST_MIN_CYC  = 32'(CLK_KHZ * RST_MIN_MS);
  localparam logic [31:0] RST_MAX_CYC  = 32'(CLK_KHZ * RST_MAX_MS);
  localparam logic [31:0] DEB_TICK_CYC = 32'(CLK_KHZ * DEB_TICK_MS);
  localparam logic [7:0]  RST_PULSE_CYC = 8'h10;
  localparam int unsigned DEB_SAMPLES  = 4;
  localparam int unsigned CARD_N       = 2;

  // ****************************************************************
  // register map
  // ****************************************************************
  localparam logic [7:0] ADDR_CTRL     = 8'h00;
  localparam logic [7:0] ADDR_STATUS   = 8'h04;
  localparam logic [7:0] ADDR_IRQ_STAT = 8'h08;
  localparam logic [7:0] ADDR_IRQ_MASK = 8'h0C;

  localparam int unsigned CTRL_RADIO = 0;
  localparam int unsigned CTRL_HP    = 1;
  localparam logic [1:0]  CTRL_RST   = 2'h2;

  localparam int unsigned ST_POWERED = 0;
  localparam int unsigned ST_RESET   = 1;
  localparam int unsigned ST_CARD0   = 2;
  localparam int unsigned ST_HP_ACT  = 4;

  localparam int unsigned IRQ_PWR_ON  = 0;
  localparam int unsigned IRQ_PWR_OFF = 1;
  localparam int unsigned IRQ_HW_RST  = 2;
  localparam int unsigned IRQ_INS0    = 3;
  localparam int unsigned IRQ_REM0    = 5;
  localparam int unsigned IRQ_W       = 7;

  typedef enum logic [1:0] {
    PWR_OFF,
    PWR_ON,
    PWR_RESET
  } mprc_pwr_t;

  typedef struct packed {
    logic [7:0]  addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
  } mprc_bus_t;

endpackage

// file: rtl/mprc_debounce.sv
// per-channel debouncer for the card insertion sense inputs
module mprc_debounce #(
  parameter int unsigned N       = 2,
  parameter int unsigned SAMPLES = 4
) (
  input  wire logic         clk_sys, // system clock
  input  wire logic         rst,     // synchronous reset
  input  wire logic         tick,    // slow sample strobe
  input  wire logic [N-1:0] raw,     // raw sense levels
  output logic      [N-1:0] stable   // debounced levels
);
  localparam int unsigned CW = $clog2(SAMPLES + 1);

  typedef struct packed {
    logic [N-1:0][CW-1:0] cnt;
    logic [N-1:0]         stable;
  } mprc_deb_st_t;

  mprc_deb_st_t s_reg;
  mprc_deb_st_t s_next;

  // ****************************************************************
  // filter
  // ****************************************************************
  always_comb begin
    s_next = s_reg;
    for (int i = 0; i < N; i++) begin
      // [R11] consecutive differing samples
      if (raw[i] == s_reg.stable[i]) begin
        s_next.cnt[i] = '0;
      end else if (tick) begin
        if (s_reg.cnt[i] == CW'(SAMPLES - 1)) begin
          s_next.stable[i] = raw[i];
          s_next.cnt[i]    = '0;
        end else begin
          s_next.cnt[i] = s_reg.cnt[i] + CW'(1);
        end
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign stable = s_reg.stable;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  chk_deb_on_tick: assert property ( // [R11]
    $changed(stable) |-> $past(tick)
      && ((($past(stable) ^ stable) & ($past(raw) ^ stable)) == '0))
    else $error("debounced level changed without a sample");

endmodule // mprc_debounce

// file: rtl/mprc_ctrl.sv
// power sequencing, reset, status lamp and card hot-plug sensing
//
// Implementation choices: the strobed register port and the register addresses.
module mprc_ctrl #(
  parameter logic [31:0] PWR_ON_CYC   = mprc_pkg::PWR_ON_CYC,
  parameter logic [31:0] RST_MIN_CYC  = mprc_pkg::RST_MIN_CYC,
  parameter logic [31:0] RST_MAX_CYC  = mprc_pkg::RST_MAX_CYC,
  parameter logic [31:0] DEB_TICK_CYC = mprc_pkg::DEB_TICK_CYC
) (
  input  wire logic              clk_sys,               // 250 MHz clock
  input  wire logic              rst,                   // sync reset
  input  wire logic              card_power_enable,     // high keeps on
  input  wire logic              host_reset_n,          // host reset
  input  wire logic              card_insert_sense_one, // card 1 sense
  input  wire logic              card_insert_sense_two, // card 2 sense
  input  wire mprc_pkg::mprc_bus_t bus,                 // register access
  output logic [31:0]            rd_data,               // read data
  output logic                   module_powered,        // module is on
  output logic                   module_reset,          // core reset
  output logic                   radio_status_lamp_n,   // lamp, low on
  output logic                   irq                    // interrupt
);
  localparam int unsigned N = mprc_pkg::CARD_N;

  typedef struct packed {
    mprc_pkg::mprc_pwr_t          st;
    logic [31:0]                  on_cnt;
    logic [31:0]                  rst_cnt;
    logic [7:0]                   pulse_cnt;
    logic [31:0]                  tick_cnt;
    logic                         tick;
    logic                         radio_en;
    logic                         hp_cfg;
    logic                         hp_act;
    logic [N-1:0]                 card_prev;
    logic [mprc_pkg::IRQ_W-1:0]   irq_stat;
    logic [mprc_pkg::IRQ_W-1:0]   irq_mask;
    logic                         powered;
    logic                         core_rst;
    logic                         lamp_n;
    logic                         irq;
    logic [31:0]                  rdata;
  } mprc_ctrl_st_t;

  mprc_ctrl_st_t s_reg;
  mprc_ctrl_st_t s_next;

  logic [N-1:0] card_raw;
  logic [N-1:0] card_stable;

  assign card_raw = {card_insert_sense_two, card_insert_sense_one};

  // ****************************************************************
  // card sense filter
  // ****************************************************************
  mprc_debounce #(
    .N       (N),
    .SAMPLES (mprc_pkg::DEB_SAMPLES)
  ) u_debounce (
    .clk_sys (clk_sys),
    .rst     (rst),
    .tick    (s_reg.tick),
    .raw     (card_raw),
    .stable  (card_stable)
  );

  // ****************************************************************
  // next state
  // ****************************************************************
  logic [mprc_pkg::IRQ_W-1:0] ev;
  logic [mprc_pkg::IRQ_W-1:0] clr;
  logic                       wr_hit;
  logic                       restart;
  logic [31:0]                status;

  always_comb begin
    s_next  = s_reg;
    ev      = '0;
    clr     = '0;
    restart = 1'b0;
    status  = '0;
    wr_hit  = bus.wr;

    // slow timebase for card sampling
    if (s_reg.tick_cnt >= DEB_TICK_CYC - 32'h1) begin
      s_next.tick_cnt = '0;
      s_next.tick     = 1'b1;
    end else begin
      s_next.tick_cnt = s_reg.tick_cnt + 32'h1;
      s_next.tick     = 1'b0;
    end

    case (s_reg.st)
      mprc_pkg::PWR_OFF: begin
        s_next.rst_cnt = '0;
        // [R2] enable held past on time
        if (!card_power_enable) begin
          s_next.on_cnt = '0;
        end else if (s_reg.on_cnt >= PWR_ON_CYC) begin
          s_next.st     = mprc_pkg::PWR_ON;
          s_next.on_cnt = '0;
          ev[mprc_pkg::IRQ_PWR_ON] = 1'b1;
          restart = 1'b1;
        end else begin
          s_next.on_cnt = s_reg.on_cnt + 32'h1;
        end
      end
      mprc_pkg::PWR_ON: begin
        if (!card_power_enable) begin
          // [R3] enable low powers off
          s_next.st      = mprc_pkg::PWR_OFF;
          s_next.rst_cnt = '0;
          ev[mprc_pkg::IRQ_PWR_OFF] = 1'b1;
        end else if (!host_reset_n) begin
          // saturate just past the window so long holds stay invalid
          if (s_reg.rst_cnt <= RST_MAX_CYC) begin
            s_next.rst_cnt = s_reg.rst_cnt + 32'h1;
          end
        end else begin
          // [R1] release inside window resets
          if (s_reg.rst_cnt >= RST_MIN_CYC &&
              s_reg.rst_cnt <= RST_MAX_CYC) begin
            s_next.st        = mprc_pkg::PWR_RESET;
            s_next.pulse_cnt = '0;
          end
          s_next.rst_cnt = '0;
        end
      end
      mprc_pkg::PWR_RESET: begin
        s_next.rst_cnt = '0;
        if (!card_power_enable) begin
          s_next.st = mprc_pkg::PWR_OFF;
          ev[mprc_pkg::IRQ_PWR_OFF] = 1'b1;
        end else if (s_reg.pulse_cnt == mprc_pkg::RST_PULSE_CYC - 8'h1) begin
          s_next.st = mprc_pkg::PWR_ON;
          ev[mprc_pkg::IRQ_HW_RST] = 1'b1;
          restart = 1'b1;
        end else begin
          s_next.pulse_cnt = s_reg.pulse_cnt + 8'h1;
        end
      end
      default: begin
        s_next.st = mprc_pkg::PWR_OFF;
      end
    endcase

    // [R10] hot-plug setting latched at restart
    if (restart) begin
      s_next.hp_act = s_reg.hp_cfg;
    end

    // [R8] high level means card inserted
    s_next.card_prev = card_stable;
    for (int i = 0; i < N; i++) begin
      // [R9] insertion and removal events
      if (s_reg.hp_act && s_reg.st == mprc_pkg::PWR_ON &&
          card_stable[i] != s_reg.card_prev[i]) begin
        ev[mprc_pkg::IRQ_INS0 + i] = card_stable[i];
        ev[mprc_pkg::IRQ_REM0 + i] = !card_stable[i];
      end
    end

    // register writes
    if (wr_hit) begin
      case (bus.addr)
        mprc_pkg::ADDR_CTRL: begin
          s_next.radio_en = bus.wdata[mprc_pkg::CTRL_RADIO];
          s_next.hp_cfg   = bus.wdata[mprc_pkg::CTRL_HP];
        end
        mprc_pkg::ADDR_IRQ_STAT: begin
          clr = bus.wdata[mprc_pkg::IRQ_W-1:0];
        end
        mprc_pkg::ADDR_IRQ_MASK: begin
          s_next.irq_mask = bus.wdata[mprc_pkg::IRQ_W-1:0];
        end
        default: begin
        end
      endcase
    end
    // a new event beats a clear in the same cycle
    s_next.irq_stat = (s_reg.irq_stat & ~clr) | ev;
    s_next.irq      = |(s_next.irq_stat & s_next.irq_mask);

    // outputs follow the next state so they leave the flops together
    s_next.powered  = (s_next.st != mprc_pkg::PWR_OFF);
    s_next.core_rst = (s_next.st == mprc_pkg::PWR_RESET);
    // [R7] lamp on while radio enabled and state is PWR_ON
    s_next.lamp_n   = !(s_next.radio_en && s_next.st == mprc_pkg::PWR_ON);

    status[mprc_pkg::ST_POWERED] = s_reg.powered;
    status[mprc_pkg::ST_RESET]   = s_reg.core_rst;
    status[mprc_pkg::ST_CARD0 +: N] = card_stable;
    status[mprc_pkg::ST_HP_ACT]  = s_reg.hp_act;

    // read data stand only in the cycle after the strobe
    s_next.rdata = '0;
    if (bus.rd) begin
      case (bus.addr)
        mprc_pkg::ADDR_CTRL: begin
          s_next.rdata[mprc_pkg::CTRL_RADIO] = s_reg.radio_en;
          s_next.rdata[mprc_pkg::CTRL_HP]    = s_reg.hp_cfg;
        end
        mprc_pkg::ADDR_STATUS: begin
          s_next.rdata = status;
        end
        mprc_pkg::ADDR_IRQ_STAT: begin
          s_next.rdata[mprc_pkg::IRQ_W-1:0] = s_reg.irq_stat;
        end
        mprc_pkg::ADDR_IRQ_MASK: begin
          s_next.rdata[mprc_pkg::IRQ_W-1:0] = s_reg.irq_mask;
        end
        default: begin
          s_next.rdata = '0;
        end
      endcase
    end
  end

  // ****************************************************************
  // state register
  // ****************************************************************
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      s_reg          <= '0;
      s_reg.st       <= mprc_pkg::PWR_OFF;
      // [R9] hot-plug enabled after reset
      s_reg.hp_cfg   <= mprc_pkg::CTRL_RST[mprc_pkg::CTRL_HP];
      s_reg.hp_act   <= mprc_pkg::CTRL_RST[mprc_pkg::CTRL_HP];
      s_reg.radio_en <= mprc_pkg::CTRL_RST[mprc_pkg::CTRL_RADIO];
      s_reg.lamp_n   <= 1'b1;
    end else begin
      s_reg <= s_next;
    end
  end

  assign rd_data             = s_reg.rdata;
  assign module_powered      = s_reg.powered;
  assign module_reset        = s_reg.core_rst;
  assign radio_status_lamp_n = s_reg.lamp_n;
  assign irq                 = s_reg.irq;

  // ****************************************************************
  // checks
  // ****************************************************************
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  sequence seq_reset_release;
    (s_reg.st == mprc_pkg::PWR_ON) && host_reset_n && card_power_enable
      && s_reg.rst_cnt >= RST_MIN_CYC && s_reg.rst_cnt <= RST_MAX_CYC;
  endsequence

  sequence seq_reset_pulse;
    module_reset[*8];
  endsequence

  // sixteen cycles, split to keep each repetition small
  sequence seq_pulse_full;
    module_reset[*8] ##1 module_reset[*8];
  endsequence

  chk_reset_window: assert property ( // [R1]
    seq_reset_release |=> (s_reg.st == mprc_pkg::PWR_RESET) ##1 seq_reset_pulse)
    else $error("valid reset hold did not reset the module");

  chk_reset_cause: assert property ( // [R1]
    $rose(module_reset) |-> $past(s_reg.rst_cnt) >= RST_MIN_CYC
      && $past(s_reg.rst_cnt) <= RST_MAX_CYC)
    else $error("core reset without a valid host hold");

  chk_power_on_hold: assert property ( // [R2]
    $rose(module_powered) |-> $past(s_reg.on_cnt) == PWR_ON_CYC
      && $past(card_power_enable))
    else $error("module powered on without full enable hold");

  chk_power_off_low: assert property ( // [R3]
    (s_reg.st != mprc_pkg::PWR_OFF && !card_power_enable)
      |=> ##1 !module_powered && !module_reset)
    else $error("enable low did not power the module off");

  chk_lamp_radio: assert property ( // [R7]
    (s_reg.radio_en && s_reg.st == mprc_pkg::PWR_ON)
      |-> !radio_status_lamp_n)
    else $error("lamp off while radio enabled");

  chk_lamp_off: assert property ( // [R7]
    (!module_powered || module_reset) |-> radio_status_lamp_n)
    else $error("lamp on while module is not running");

  chk_insert_event: assert property ( // [R8]
    ($rose(card_stable[0]) && s_reg.hp_act
      && s_reg.st == mprc_pkg::PWR_ON && $stable(s_reg.st))
      |=> s_reg.irq_stat[mprc_pkg::IRQ_INS0])
    else $error("card insertion not reported");

  chk_hp_default: assert property ( // [R9]
    $past(rst) |-> s_reg.hp_cfg && s_reg.hp_act)
    else $error("hot-plug not enabled after reset");

  chk_hp_latch: assert property ( // [R10]
    $changed(s_reg.hp_act) |-> $past(s_reg.st) != mprc_pkg::PWR_ON
      && s_reg.st == mprc_pkg::PWR_ON)
    else $error("hot-plug setting applied without restart");

  chk_hp_off_quiet: assert property ( // [R10]
    !s_reg.hp_act |=> (s_reg.irq_stat[mprc_pkg::IRQ_INS0 +: N]
      & ~$past(s_reg.irq_stat[mprc_pkg::IRQ_INS0 +: N])) == '0)
    else $error("card event with hot-plug inactive");

  // [R1] pulse never overruns
  chk_pulse_bound: assert property ( // [R1]
    seq_pulse_full |=> !module_reset)
    else $error("core reset pulse too long");

  // [R1] pulse ends only when full, unless enable low cuts it short
  chk_pulse_full: assert property ( // [R1]
    ($fell(module_reset) && module_powered)
      |-> $past(s_reg.pulse_cnt) == mprc_pkg::RST_PULSE_CYC - 8'h1)
    else $error("core reset pulse too short");

  // [R1] no reset while off
  chk_reset_off: assert property ( // [R1]
    (s_reg.st == mprc_pkg::PWR_OFF) |=> !module_reset)
    else $error("core reset raised while powered off");

  // [R7] lamp dark, radio off
  chk_lamp_dark: assert property ( // [R7]
    !s_reg.radio_en |-> radio_status_lamp_n)
    else $error("lamp on while radio disabled");

  // [R8] removal reported per card
  for (genvar g = 0; g < N; g++) begin : g_rem_chk
    chk_remove_event: assert property ( // [R8]
      @(posedge clk_sys) disable iff (rst)
      ($fell(card_stable[g]) && s_reg.hp_act
        && s_reg.st == mprc_pkg::PWR_ON)
        |=> s_reg.irq_stat[mprc_pkg::IRQ_REM0 + g])
      else $error("card removal not reported");
  end : g_rem_chk

  // [R9] no card events unless on
  chk_off_no_card: assert property ( // [R9]
    s_reg.st != mprc_pkg::PWR_ON
      |=> (s_reg.irq_stat[mprc_pkg::IRQ_INS0 +: 2*N]
      & ~$past(s_reg.irq_stat[mprc_pkg::IRQ_INS0 +: 2*N])) == '0)
    else $error("card event while module not running");

  // read data stand for one cycle only
  chk_rd_idle: assert property (
    !$past(bus.rd) |-> rd_data == 32'h0)
    else $error("read data outside the read answer");

endmodule // mprc_ctrl

// file: verification/mprc_host_model.sv
// host processor model driving the power and reset requests
module mprc_host_model #(
  parameter int unsigned SUPPLY_WAIT = 10,
  parameter int unsigned RST_GAP     = 80
) (
  input  wire logic clk_sys,           // system clock
  output logic      card_power_enable, // power enable
  output logic      host_reset_n       // reset request
);
  timeunit 1ns;
  timeprecision 1ps;

  int unsigned cyc      = 0;
  int unsigned last_rst = 0;

  initial begin
    card_power_enable = 1'b0;
    host_reset_n      = 1'b1;
  end

  always @(posedge clk_sys) cyc <= cyc + 1;

  task automatic set_enable(logic v, int n);
    while (cyc < SUPPLY_WAIT) @(posedge clk_sys);
    @(posedge clk_sys);
    card_power_enable <= v;
    repeat (n) @(posedge clk_sys);
  endtask

  // spaced low pulse
  // gap stands in for the long real spacing to keep the run short
  task automatic reset_pulse(int n);
    while (cyc - last_rst < RST_GAP) @(posedge clk_sys);
    @(posedge clk_sys);
    host_reset_n <= 1'b0;
    repeat (n) @(posedge clk_sys);
    host_reset_n <= 1'b1;
    last_rst = cyc;
  endtask
endmodule // mprc_host_model

// file: verification/tb_top.sv
// self-checking bench for the module power and reset control
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;

  localparam logic [31:0] T_ON = 32'h14;

  logic                clk_sys;
  logic                rst;
  logic                card_power_enable;
  logic                host_reset_n;
  logic [1:0]          sense;
  mprc_pkg::mprc_bus_t bus;
  logic [31:0]         rd_data;
  logic                module_powered;
  logic                module_reset;
  logic                radio_status_lamp_n;
  logic                irq;
  int                  n_fail = 0;
  int                  comparisons = 0;
  int                  seed;
  int                  pulse_len;
  int                  pulse_base;
  int                  n;

  initial clk_sys = 1'b0;
  always #2 clk_sys = ~clk_sys;

  mprc_host_model u_host (
    .clk_sys           (clk_sys),
    .card_power_enable (card_power_enable),
    .host_reset_n      (host_reset_n)
  );

  mprc_ctrl #(
    .PWR_ON_CYC   (T_ON),
    .RST_MIN_CYC  (32'h0A),
    .RST_MAX_CYC  (32'h28),
    .DEB_TICK_CYC (32'h04)
  ) u_dut (
    .clk_sys               (clk_sys),
    .rst                   (rst),
    .card_power_enable     (card_power_enable),
    .host_reset_n          (host_reset_n),
    .card_insert_sense_one (sense[0]),
    .card_insert_sense_two (sense[1]),
    .bus                   (bus),
    .rd_data               (rd_data),
    .module_powered        (module_powered),
    .module_reset          (module_reset),
    .radio_status_lamp_n   (radio_status_lamp_n),
    .irq                   (irq)
  );

  // only this process writes the pulse counter
  always @(posedge clk_sys) begin
    if (module_reset === 1'b1) pulse_len <= pulse_len + 1;
  end

  // ********
  // helpers
  // ********
  task automatic results;
    $display("comparisons %0d n_fail %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_fail++;
      $display("CHECK FAILED %s expected %0h seen %0h", what, exp, seen);
    end
  endtask

  task automatic wait_cyc(int c);
    repeat (c) @(posedge clk_sys);
    #1;
  endtask

  task automatic wr(logic [7:0] a, logic [31:0] v);
    @(posedge clk_sys);
    bus.wr    <= 1'b1;
    bus.addr  <= a;
    bus.wdata <= v;
    @(posedge clk_sys);
    bus.wr    <= 1'b0;
  endtask

  task automatic rd(logic [7:0] a, output logic [31:0] d);
    @(posedge clk_sys);
    bus.rd   <= 1'b1;
    bus.addr <= a;
    @(posedge clk_sys);
    bus.rd   <= 1'b0;
    #1 d = rd_data;
  endtask

  task automatic rd_chk(string what, logic [7:0] a, logic [31:0] e);
    logic [31:0] d;
    rd(a, d);
    check(what, d, e);
  endtask

  task automatic rd_bit(string what, logic [7:0] a, int b, logic e);
    logic [31:0] d;
    rd(a, d);
    check(what, 32'(d[b]), 32'(e));
  endtask

  function automatic logic [31:0] exp_card(int ch, logic v, logic ev);
    int b;
    b = v ? mprc_pkg::IRQ_INS0 + ch : mprc_pkg::IRQ_REM0 + ch;
    return ev ? 32'h1 << b : 32'h0;
  endfunction

  // short bounce first, then a settled change
  task automatic card_set(int ch, logic v, logic ev);
    @(posedge clk_sys);
    sense[ch] <= v;
    repeat (1 + $unsigned($random(seed)) % 5) @(posedge clk_sys);
    sense[ch] <= ~v;
    wait_cyc(24);
    rd_bit("card bounce", mprc_pkg::ADDR_STATUS, 2 + ch, ~v);
    @(posedge clk_sys);
    sense[ch] <= v;
    wait_cyc(40);
    rd_bit("card level", mprc_pkg::ADDR_STATUS, 2 + ch, v);
    rd_chk("card event", mprc_pkg::ADDR_IRQ_STAT, exp_card(ch, v, ev));
    wr(mprc_pkg::ADDR_IRQ_STAT, 32'h7F);
  endtask

  initial begin
    repeat (30000) @(posedge clk_sys);
    n_fail++;
    results();
  end

  // ********
  // tests
  // ********
  initial begin
    seed = 68;
    rst = 1'b1;
    sense = 2'h0;
    bus = '0;
    repeat (8) @(posedge clk_sys);
    rst <= 1'b0;
    wait_cyc(1);
    rd_chk("ctrl", mprc_pkg::ADDR_CTRL, 32'h2);
    rd_chk("status", mprc_pkg::ADDR_STATUS, 32'h10);
    rd_chk("mask", mprc_pkg::ADDR_IRQ_MASK, 32'h0);
    rd_chk("unmapped", 8'h10, 32'h0);
    check("lamp idle", 32'(radio_status_lamp_n), 32'h1);
    $display("test reset values done");

    wr(mprc_pkg::ADDR_IRQ_MASK, 32'h7F);
    u_host.set_enable(1'b1, T_ON - 4);
    u_host.set_enable(1'b0, 4);
    wait_cyc(1);
    check("short enable", 32'(module_powered), 32'h0);
    u_host.set_enable(1'b1, T_ON + 4);
    wait_cyc(1);
    check("powered", 32'(module_powered), 32'h1);
    rd_chk("on event", mprc_pkg::ADDR_IRQ_STAT, 32'h1);
    check("irq on", 32'(irq), 32'h1);
    wr(mprc_pkg::ADDR_IRQ_STAT, 32'h7F);
    wait_cyc(2);
    check("irq clear", 32'(irq), 32'h0);
    $display("test power on done");

    wr(mprc_pkg::ADDR_CTRL, 32'h3);
    wait_cyc(2);
    check("lamp on", 32'(radio_status_lamp_n), 32'h0);
    wr(mprc_pkg::ADDR_CTRL, 32'h2);
    wait_cyc(2);
    check("lamp off", 32'(radio_status_lamp_n), 32'h1);
    $display("test lamp done");

    for (int i = 0; i < 3; i++) begin
      n = (i == 0) ? 4 : (i == 1) ? 60 : 12 + $unsigned($random(seed)) % 27;
      pulse_base = pulse_len;
      u_host.reset_pulse(n);
      wait_cyc(30);
      check("reset pulse", 32'(pulse_len - pulse_base),
            (i == 2) ? 32'(mprc_pkg::RST_PULSE_CYC) : 32'h0);
    end
    rd_chk("reset event", mprc_pkg::ADDR_IRQ_STAT, 32'h4);
    wr(mprc_pkg::ADDR_IRQ_STAT, 32'h7F);
    $display("test hardware reset done");

    for (int k = 0; k < 6; k++) begin
      n = $unsigned($random(seed)) % 2;
      card_set(n, ~sense[n], 1'b1);
    end
    $display("test card sense done");

    wr(mprc_pkg::ADDR_CTRL, 32'h0);
    rd_bit("hp kept", mprc_pkg::ADDR_STATUS, 4, 1'b1);
    card_set(0, ~sense[0], 1'b1);
    u_host.reset_pulse(20);
    wait_cyc(30);
    wr(mprc_pkg::ADDR_IRQ_STAT, 32'h7F);
    rd_bit("hp applied", mprc_pkg::ADDR_STATUS, 4, 1'b0);
    card_set(1, ~sense[1], 1'b0);
    $display("test hot plug setting done");

    wr(mprc_pkg::ADDR_IRQ_MASK, 32'h0);
    u_host.set_enable(1'b0, 3);
    wait_cyc(1);
    check("powered off", 32'(module_powered), 32'h0);
    rd_chk("off event", mprc_pkg::ADDR_IRQ_STAT, 32'h2);
    check("irq masked", 32'(irq), 32'h0);
    wr(mprc_pkg::ADDR_IRQ_MASK, 32'h7F);
    wait_cyc(2);
    check("irq unmasked", 32'(irq), 32'h1);
    $display("test power off done");
    results();
  end
endmodule // tb_top
